// ===== src/gppa_defs.vh
`ifndef GPPA_DEFS_VH
`define GPPA_DEFS_VH

// ==================================================================
// Register byte offsets (address bits [7:0] are decoded).
`define GPPA_OFF_GLOBAL   8'h00
`define GPPA_OFF_P1_LATCH 8'h04
`define GPPA_OFF_P3_LATCH 8'h08
`define GPPA_OFF_P1_PINS  8'h0c
`define GPPA_OFF_P3_PINS  8'h10
`define GPPA_OFF_SCTL     8'h14
`define GPPA_OFF_SDAT     8'h18

// ==================================================================
// Field positions.
`define GPPA_GC_P1_PUD    0
`define GPPA_GC_P3_PUD    1
`define GPPA_SC_RXDONE    0
`define GPPA_SC_TXDONE    1
`define GPPA_SC_RB8       2
`define GPPA_SC_TB8       3
`define GPPA_SC_REN       4
`define GPPA_SC_MODE_LO   6
`define GPPA_SC_MODE_HI   7

// ==================================================================
// Reset values.
`define GPPA_GC_RST       2'h0
`define GPPA_LATCH_RST    8'hff
`define GPPA_SCTL_RST     8'h00
`define GPPA_SDAT_RST     8'h00

// ==================================================================
// Serial modes and timing.
`define GPPA_MODE_SYNC    2'h0
`define GPPA_MODE_ASYNC8  2'h1
`define GPPA_SYNC_DIV     16'h000c
`define GPPA_SYNC_HALF    16'h0006
`define GPPA_SYNC_BITS    4'h8
`define GPPA_TX8_BITS     4'ha
`define GPPA_TX9_BITS     4'hb
`define GPPA_RX8_BITS     4'h9
`define GPPA_RX9_BITS     4'ha

`endif

// ===== src/gppa_port.v
// Functional notes
// [RQ1] Each pin has data in, data out and an active-low output enable; the pad output enables port1_pad_oe_o and port3_pad_oe_o are active-high.
// [RQ2] Output 0 is sunk actively; output 1 is held by the weak pullup.
// [RQ3] Enable is data-out AND two-clock delayed data-out; drives 1 briefly.
// [RQ4] Firmware sets data-out to 1 to use a pin as input.
// [RQ5] Per-port pullup-disable bit makes a released 1 go high impedance.
// [RQ6] After reset every pin is an input with pullups enabled.
// [RQ7] Port-3 bits 0 and 1 become inputs once reset is released.
// [RQ8] Port-3 alternate inputs come straight from pad data in; still readable.
// [RQ9] Port-3 data-out is port latch AND that bit's alternate output.
// [RQ10] Unused alternate outputs idle at logic 1.
// [RQ11] Serial mode 0: data on port-3 bit 0, clock/12 on bit 1.
// [RQ12] Modes 1 to 3: receive on bit 0, transmit on bit 1, full duplex.
// [RQ13] Transmission starts only on serial buffer write; outputs idle high.
// [RQ14] Receive-enable bit gates reception; general input use is harmless.
// [RQ15] Firmware sets serial pin latch to 1 and avoids the serial buffer.
// [RQ16] Pullup-disable bits reset to 0; delay stages reset to idle state.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "gppa_defs.vh"

module gppa_port #(
    parameter [15:0] BAUD_CYCLES = 16'h0010
) (
    // Clock and reset.
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    // AHB-Lite slave.
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire        hreadyout_o,
    output wire        hresp_o,
    output reg  [31:0] hrdata_o,
    // Port 1 pads.
    input  wire [7:0]  port1_pad_data_in_i,
    output wire [7:0]  port1_pad_data_out_o,
    output wire [7:0]  port1_pad_oe_o,
    output wire        port1_pullup_en_o,
    // Port 3 pads.
    input  wire [7:0]  port3_pad_data_in_i,
    output wire [7:0]  port3_pad_data_out_o,
    output wire [7:0]  port3_pad_oe_o,
    output wire        port3_pullup_en_o,
    // Port 3 alternates for internal units (bits 1:0 belong to the UART).
    input  wire [7:2]  port3_alt_out_i,
    output wire [7:0]  port3_alt_in_o
);

    // ==================================================================
    // State encodings.
    localparam [2:0] TX_IDLE  = 3'b001;
    localparam [2:0] TX_SYNC  = 3'b010;
    localparam [2:0] TX_ASYNC = 3'b100;
    localparam [2:0] RX_IDLE  = 3'b001;
    localparam [2:0] RX_START = 3'b010;
    localparam [2:0] RX_DATA  = 3'b100;

    // Active-low pad enable: low drives the pin, high listens.
    function [7:0] gppa_pad_en_n;
        input [7:0] dout;
        input [7:0] dout_d2;
        begin
            gppa_pad_en_n = dout & dout_d2;
        end
    endfunction

    // ==================================================================
    // Reset release.
    reg rst_meta_reg;
    reg rst_n_reg;

    // Reset asserts at once and releases two edges later.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ==================================================================
    // Pin input synchronisers.
    reg [7:0] p1_meta_reg;
    reg [7:0] p1_sync_reg;
    reg [7:0] p3_meta_reg;
    reg [7:0] p3_sync_reg;

    // Pins are asynchronous; only the second stage is used.
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            p1_meta_reg <= `GPPA_LATCH_RST;
            p1_sync_reg <= `GPPA_LATCH_RST;
            p3_meta_reg <= `GPPA_LATCH_RST;
            p3_sync_reg <= `GPPA_LATCH_RST;
        end else begin
            p1_meta_reg <= port1_pad_data_in_i;
            p1_sync_reg <= p1_meta_reg;
            p3_meta_reg <= port3_pad_data_in_i;
            p3_sync_reg <= p3_meta_reg;
        end
    end

    // Alternate inputs bypass the latch, the port read sees them too.
    assign port3_alt_in_o = p3_sync_reg; // RQ8

    // ==================================================================
    // Register file.
    reg  [1:0]  gc_reg;
    reg  [7:0]  p1_latch_reg;
    reg  [7:0]  p3_latch_reg;
    reg  [7:0]  sctl_reg;
    reg  [7:0]  sdat_rx_reg;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg         rx_done_set;
    reg         tx_done_set;
    reg         rb8_val;
    reg  [7:0]  rx_byte;
    wire        addr_ok;
    wire        wr_now;
    wire        sdat_wr;
    wire [1:0]  mode;
    reg  [31:0] rd_next;

    // Zero-wait slave: every transfer completes with OKAY.
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign addr_ok     = hsel_i & hready_i & htrans_i[1];
    assign wr_now      = wr_pend_reg;
    assign sdat_wr     = wr_now & (wr_addr_reg == `GPPA_OFF_SDAT);
    assign mode        = sctl_reg[`GPPA_SC_MODE_HI:`GPPA_SC_MODE_LO];

    // Read data is decoded in the address phase; unmapped reads are zero.
    always @* begin
        rd_next = 32'h0000_0000;
        case (haddr_i[7:0])
            `GPPA_OFF_GLOBAL:   rd_next[1:0] = gc_reg;
            `GPPA_OFF_P1_LATCH: rd_next[7:0] = p1_latch_reg;
            `GPPA_OFF_P3_LATCH: rd_next[7:0] = p3_latch_reg;
            `GPPA_OFF_P1_PINS:  rd_next[7:0] = p1_sync_reg;
            `GPPA_OFF_P3_PINS:  rd_next[7:0] = p3_sync_reg;
            `GPPA_OFF_SCTL:     rd_next[7:0] = sctl_reg;
            `GPPA_OFF_SDAT:     rd_next[7:0] = sdat_rx_reg;
            default:            rd_next = 32'h0000_0000;
        endcase
    end

    // Address phase capture, data phase write; done flags set over clear.
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 8'h00;
            hrdata_o     <= 32'h0000_0000;
            gc_reg       <= `GPPA_GC_RST;    // RQ16
            p1_latch_reg <= `GPPA_LATCH_RST; // RQ6
            p3_latch_reg <= `GPPA_LATCH_RST; // RQ7
            sctl_reg     <= `GPPA_SCTL_RST;
            sdat_rx_reg  <= `GPPA_SDAT_RST;
        end else begin
            wr_pend_reg <= addr_ok & hwrite_i;
            wr_addr_reg <= haddr_i[7:0];
            if (addr_ok & ~hwrite_i) begin
                hrdata_o <= rd_next;
            end
            if (wr_now) begin
                case (wr_addr_reg)
                    `GPPA_OFF_GLOBAL:   gc_reg <= hwdata_i[1:0];
                    `GPPA_OFF_P1_LATCH: p1_latch_reg <= hwdata_i[7:0];
                    `GPPA_OFF_P3_LATCH: p3_latch_reg <= hwdata_i[7:0];
                    `GPPA_OFF_SCTL:     sctl_reg <= hwdata_i[7:0];
                    default:            gc_reg <= gc_reg;
                endcase
            end
            if (rx_done_set) begin
                sctl_reg[`GPPA_SC_RXDONE] <= 1'b1;
                sctl_reg[`GPPA_SC_RB8]    <= rb8_val;
                sdat_rx_reg               <= rx_byte;
            end
            if (tx_done_set) begin
                sctl_reg[`GPPA_SC_TXDONE] <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Serial transmitter.
    reg [2:0]  tx_state_reg;
    reg [15:0] tx_cnt_reg;
    reg [3:0]  tx_bits_reg;
    reg [10:0] tx_sr_reg;
    reg        alt0_reg;
    reg        alt1_reg;

    // Alternate outputs rest at 1 until the serial buffer is written.
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 16'h0000;
            tx_bits_reg  <= 4'h0;
            tx_sr_reg    <= 11'h7ff;
            alt0_reg     <= 1'b1; // RQ10
            alt1_reg     <= 1'b1; // RQ10
            tx_done_set  <= 1'b0;
        end else begin
            tx_done_set <= 1'b0;
            case (tx_state_reg)
                TX_IDLE: begin
                    alt0_reg <= 1'b1;
                    alt1_reg <= 1'b1;
                    tx_cnt_reg  <= 16'h0000;
                    tx_bits_reg <= 4'h0;
                    if (sdat_wr) begin // RQ13
                        if (mode == `GPPA_MODE_SYNC) begin
                            tx_sr_reg    <= {3'b111, hwdata_i[7:0]};
                            tx_state_reg <= TX_SYNC;
                        end else begin
                            tx_sr_reg <= {1'b1,
                                ((mode == `GPPA_MODE_ASYNC8) |
                                 sctl_reg[`GPPA_SC_TB8]),
                                hwdata_i[7:0], 1'b0};
                            tx_state_reg <= TX_ASYNC;
                        end
                    end
                end
                TX_SYNC: begin
                    // Data on bit 0, clock low then high each 12 cycles.
                    alt0_reg <= tx_sr_reg[0]; // RQ11
                    alt1_reg <= (tx_cnt_reg >= `GPPA_SYNC_HALF); // RQ11
                    if (tx_cnt_reg == `GPPA_SYNC_DIV - 16'h0001) begin
                        tx_cnt_reg  <= 16'h0000;
                        tx_sr_reg   <= {1'b1, tx_sr_reg[10:1]};
                        tx_bits_reg <= tx_bits_reg + 4'h1;
                        if (tx_bits_reg == `GPPA_SYNC_BITS - 4'h1) begin
                            tx_state_reg <= TX_IDLE;
                            tx_done_set  <= 1'b1;
                        end
                    end else begin
                        tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                    end
                end
                TX_ASYNC: begin
                    // Frame leaves on bit 1; bit 0 stays free for receive.
                    alt0_reg <= 1'b1;
                    alt1_reg <= tx_sr_reg[0]; // RQ12
                    if (tx_cnt_reg == BAUD_CYCLES - 16'h0001) begin
                        tx_cnt_reg  <= 16'h0000;
                        tx_sr_reg   <= {1'b1, tx_sr_reg[10:1]};
                        tx_bits_reg <= tx_bits_reg + 4'h1;
                        if (tx_bits_reg == ((mode == `GPPA_MODE_ASYNC8) ?
                                `GPPA_TX8_BITS : `GPPA_TX9_BITS) - 4'h1)
                        begin
                            tx_state_reg <= TX_IDLE;
                            tx_done_set  <= 1'b1;
                        end
                    end else begin
                        tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Serial receiver (modes 1 to 3), independent of the transmitter.
    reg  [2:0]  rx_state_reg;
    reg  [15:0] rx_cnt_reg;
    reg  [3:0]  rx_bits_reg;
    reg  [9:0]  rx_sr_reg;
    wire        rx_pin;
    wire        rx_go;

    assign rx_pin = p3_sync_reg[0];
    // Without the receive enable the pin is ignored entirely.
    assign rx_go  = sctl_reg[`GPPA_SC_REN] &
                    (mode != `GPPA_MODE_SYNC); // RQ14

    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_bits_reg  <= 4'h0;
            rx_sr_reg    <= 10'h000;
            rx_done_set  <= 1'b0;
            rx_byte      <= 8'h00;
            rb8_val      <= 1'b0;
        end else begin
            rx_done_set <= 1'b0;
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_cnt_reg  <= 16'h0000;
                    rx_bits_reg <= 4'h0;
                    if (rx_go & ~rx_pin) begin // RQ12
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    // Recheck the start bit mid-bit to reject glitches.
                    if (!rx_go) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (rx_cnt_reg == {1'b0, BAUD_CYCLES[15:1]}) begin
                        rx_cnt_reg   <= 16'h0000;
                        rx_state_reg <= rx_pin ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (!rx_go) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (rx_cnt_reg == BAUD_CYCLES - 16'h0001) begin
                        rx_cnt_reg             <= 16'h0000;
                        rx_sr_reg[rx_bits_reg] <= rx_pin;
                        rx_bits_reg            <= rx_bits_reg + 4'h1;
                        if (rx_bits_reg == ((mode == `GPPA_MODE_ASYNC8) ?
                                `GPPA_RX8_BITS : `GPPA_RX9_BITS) - 4'h1)
                        begin
                            rx_state_reg <= RX_IDLE;
                            rx_done_set  <= 1'b1;
                            rx_byte      <= rx_sr_reg[7:0];
                            rb8_val      <= (mode == `GPPA_MODE_ASYNC8) ?
                                            rx_pin : rx_sr_reg[8];
                        end
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Pad drive.
    reg  [7:0] p1_do_reg;
    reg  [7:0] p1_d1_reg;
    reg  [7:0] p1_d2_reg;
    reg  [7:0] p3_do_reg;
    reg  [7:0] p3_d1_reg;
    reg  [7:0] p3_d2_reg;
    wire [7:0] p3_alt;
    wire [7:0] p1_en_n;
    wire [7:0] p3_en_n;

    assign p3_alt = {port3_alt_out_i, alt1_reg, alt0_reg};

    // Delay stages idle at 1 so the pads come out of reset listening.
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            p1_do_reg <= `GPPA_LATCH_RST; // RQ6
            p1_d1_reg <= `GPPA_LATCH_RST; // RQ16
            p1_d2_reg <= `GPPA_LATCH_RST; // RQ16
            p3_do_reg <= `GPPA_LATCH_RST; // RQ7
            p3_d1_reg <= `GPPA_LATCH_RST;
            p3_d2_reg <= `GPPA_LATCH_RST;
        end else begin
            p1_do_reg <= p1_latch_reg;
            p3_do_reg <= p3_latch_reg & p3_alt; // RQ9
            p1_d1_reg <= p1_do_reg;
            p1_d2_reg <= p1_d1_reg; // RQ3
            p3_d1_reg <= p3_do_reg;
            p3_d2_reg <= p3_d1_reg; // RQ3
        end
    end

    // A 0 drives low; a new 1 drives high two clocks, then releases.
    assign p1_en_n = gppa_pad_en_n(p1_do_reg, p1_d2_reg); // RQ3
    assign p3_en_n = gppa_pad_en_n(p3_do_reg, p3_d2_reg); // RQ3

    assign port1_pad_data_out_o = p1_do_reg; // RQ1
    assign port3_pad_data_out_o = p3_do_reg; // RQ1
    assign port1_pad_oe_o       = ~p1_en_n;  // RQ2
    assign port3_pad_oe_o       = ~p3_en_n;  // RQ2

    // A released 1 floats when the port's pullup is disabled.
    assign port1_pullup_en_o = ~gc_reg[`GPPA_GC_P1_PUD]; // RQ5
    assign port3_pullup_en_o = ~gc_reg[`GPPA_GC_P3_PUD]; // RQ5

endmodule

// ===== test/gpio_pad_port_with_alternates_tb_top.sv
`timescale 1ns/10ps
`include "gppa_defs.vh"

module gpio_pad_port_with_alternates_tb_top;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg  [5:0]  alt_out = 6'h3f;
    reg  [7:0]  p1_den = 8'h00;
    reg  [7:0]  p3_den = 8'h00;
    reg  [7:0]  p3_dval = 8'h00;
    reg         loop = 1'b0;
    reg  [31:0] rd;
    wire        hreadyout;
    wire        hresp;
    wire [31:0] hrdata;
    wire [7:0]  p1_do, p1_oe, p1_pin, p3_do, p3_oe, p3_pin, alt_in;
    wire        p1_pu, p3_pu;
    integer     miscompares = 0;
    integer     comparisons = 0;
    integer     lo_n, hi_n, skip_n;

    // 100 MHz clock.
    always #5 clk = ~clk;

    gppa_port #(.BAUD_CYCLES(16'h0008)) gppa_port_i (
        .ref_clk_i(clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .hrdata_o(hrdata), .port1_pad_data_in_i(p1_pin),
        .port1_pad_data_out_o(p1_do), .port1_pad_oe_o(p1_oe),
        .port1_pullup_en_o(p1_pu), .port3_pad_data_in_i(p3_pin),
        .port3_pad_data_out_o(p3_do), .port3_pad_oe_o(p3_oe),
        .port3_pullup_en_o(p3_pu), .port3_alt_out_i(alt_out),
        .port3_alt_in_o(alt_in));
    gppa_ext_dev gppa_ext_dev_p1_i (
        .ref_clk_i(clk), .data_out_i(p1_do), .oe_i(p1_oe),
        .pullup_en_i(p1_pu), .drive_en_i(p1_den), .drive_val_i(8'h00),
        .pin_o(p1_pin));
    // Loop wires the transmit pin onto the receive pin.
    gppa_ext_dev gppa_ext_dev_p3_i (
        .ref_clk_i(clk), .data_out_i(p3_do), .oe_i(p3_oe),
        .pullup_en_i(p3_pu), .drive_en_i(p3_den | {7'h00, loop}),
        .drive_val_i(loop ? {p3_dval[7:1], p3_do[1]} : p3_dval),
        .pin_o(p3_pin));

    // ======================================================
    // Checking and bus tasks
    task give_verdict;
        begin
            if (miscompares == 0 && comparisons > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    task hang;
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    endtask

    task cmp(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h",
                         $time, got, exp);
            end
        end
    endtask

    task wait_ready;
        integer n;
        begin
            n = 0;
            @(posedge clk);
            while (hreadyout !== 1'b1) begin
                n = n + 1;
                if (n > 50) hang;
                @(posedge clk);
            end
        end
    endtask

    // One single transfer; each phase waits for ready.
    task bus(input [7:0] a, input w, input [31:0] wd);
        begin
            @(posedge clk);
            hsel   <= 1'b1;
            haddr  <= {24'h0, a};
            hwrite <= w;
            htrans <= 2'h2;
            wait_ready;
            htrans <= 2'h0;
            hwdata <= wd;
            wait_ready;
            rd = hrdata;
        end
    endtask

    task rdc(input [7:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 32'h0);
            cmp(rd, e);
        end
    endtask

    task poll(input [31:0] mask);
        integer n;
        begin
            n = 0;
            rd = 32'h0;
            while ((rd & mask) == 32'h0) begin
                n = n + 1;
                if (n > 200) hang;
                bus(`GPPA_OFF_SCTL, 1'b0, 32'h0);
            end
        end
    endtask

    // Counts edges until the clock pin shows a level.
    task wait_lvl(input b, output integer n);
        begin
            n = 0;
            while (p3_do[1] !== b) begin
                @(posedge clk);
                n = n + 1;
                if (n > 100) hang;
            end
        end
    endtask

    // ======================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({16'h0, p1_oe, p3_oe}, 32'h0);
        cmp({30'h0, p1_pu, p3_pu}, 32'h3);
        cmp({24'h0, alt_in}, 32'hff);
        rdc(`GPPA_OFF_GLOBAL, 32'h0);
        rdc(8'h1c, 32'h0);
        bus(`GPPA_OFF_P1_LATCH, 1'b1, 32'h5a);
        repeat (2) @(posedge clk);
        cmp({24'h0, p1_oe}, 32'ha5);
        rdc(`GPPA_OFF_P1_PINS, 32'h5a);
        bus(`GPPA_OFF_P1_LATCH, 1'b1, 32'hff);
        repeat (5) @(posedge clk);
        cmp({24'h0, p1_oe}, 32'h0);
        p1_den <= 8'h0f;
        repeat (4) @(posedge clk);
        rdc(`GPPA_OFF_P1_PINS, 32'hf0);
        p1_den <= 8'h00;
        bus(`GPPA_OFF_GLOBAL, 1'b1, 32'h3);
        rdc(`GPPA_OFF_GLOBAL, 32'h3);
        cmp({30'h0, p1_pu, p3_pu}, 32'h0);
        bus(`GPPA_OFF_GLOBAL, 1'b1, 32'h0);
        alt_out <= 6'h3e;
        bus(`GPPA_OFF_P3_LATCH, 1'b1, 32'hf7);
        repeat (2) @(posedge clk);
        cmp({24'h0, p3_do}, 32'hf3);
        alt_out <= 6'h3f;
        bus(`GPPA_OFF_P3_LATCH, 1'b1, 32'hff);
        p3_den <= 8'hf0;
        p3_dval <= 8'h5a;
        repeat (4) @(posedge clk);
        rdc(`GPPA_OFF_P3_PINS, 32'h5f);
        cmp({24'h0, alt_in}, 32'h5f);
        cmp({30'h0, p3_do[1:0]}, 32'h3);
        // Receiver off: a low pulse is ignored.
        bus(`GPPA_OFF_SCTL, 1'b1, 32'h40);
        p3_den <= 8'h01;
        p3_dval <= 8'h00;
        repeat (40) @(posedge clk);
        p3_den <= 8'h00;
        repeat (100) @(posedge clk);
        rdc(`GPPA_OFF_SCTL, 32'h40);
        // Mode 0: clock low six, high six, data on bit 0.
        bus(`GPPA_OFF_SCTL, 1'b1, 32'h00);
        bus(`GPPA_OFF_SDAT, 1'b1, 32'h5a);
        wait_lvl(1'b0, skip_n);
        wait_lvl(1'b1, lo_n);
        cmp({31'h0, p3_do[0]}, 32'h0);
        wait_lvl(1'b0, hi_n);
        cmp(lo_n + hi_n, 32'd12);
        poll(32'h2);
        // Mode 1, looped back.
        bus(`GPPA_OFF_SCTL, 1'b1, 32'h50);
        loop <= 1'b1;
        bus(`GPPA_OFF_SDAT, 1'b1, 32'h3c);
        poll(32'h1);
        rdc(`GPPA_OFF_SDAT, 32'h3c);
        loop <= 1'b0;
        // A second reset restores inputs with pullups.
        bus(`GPPA_OFF_GLOBAL, 1'b1, 32'h3);
        bus(`GPPA_OFF_P1_LATCH, 1'b1, 32'h00);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({22'h0, p1_pu, p3_pu, p1_oe}, 32'h300);
        give_verdict;
    end
endmodule

// ===== test/gppa_ext_dev.sv
`timescale 1ns/10ps

module gppa_ext_dev (
    // Clock.
    input  wire       ref_clk_i,
    // Pad side of the port.
    input  wire [7:0] data_out_i,
    input  wire [7:0] oe_i,
    input  wire       pullup_en_i,
    // Outside source on the wires.
    input  wire [7:0] drive_en_i,
    input  wire [7:0] drive_val_i,
    output reg  [7:0] pin_o
);
    reg     [7:0] last_reg = 8'h00;
    integer       k;

    // A floating wire flips each cycle so it never matches by luck.
    always @* begin
        for (k = 0; k < 8; k = k + 1) begin
            if (oe_i[k]) begin
                pin_o[k] = data_out_i[k];
            end else if (drive_en_i[k]) begin
                pin_o[k] = drive_val_i[k];
            end else if (pullup_en_i) begin
                pin_o[k] = 1'b1;
            end else begin
                pin_o[k] = ~last_reg[k];
            end
        end
    end

    // Last level of each wire.
    always @(posedge ref_clk_i) begin
        last_reg <= pin_o;
    end
endmodule

// ===== test/gppa_port_assertions.sv
`timescale 1ns/10ps
`include "gppa_defs.vh"

module gppa_port_chk #(
    parameter [15:0] BAUD_CYCLES = 16'h0010
) (
    // Clock, reset and bus.
    input wire        ref_clk_i,
    input wire        arst_n_i,
    input wire        hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire        hreadyout_o,
    input wire        hresp_o,
    // Pads and alternates.
    input wire [7:0]  port1_pad_data_out_o,
    input wire [7:0]  port1_pad_oe_o,
    input wire        port1_pullup_en_o,
    input wire [7:0]  port3_pad_data_in_i,
    input wire [7:0]  port3_pad_data_out_o,
    input wire [7:0]  port3_pad_oe_o,
    input wire        port3_pullup_en_o,
    input wire [7:2]  port3_alt_out_i,
    input wire [7:0]  port3_alt_in_o
);
    reg       p1_aph_reg;
    reg       p1_due_reg;
    reg [7:0] p1_val_reg;
    reg [2:0] age_reg;

    // ======================================================
    // Helper state
    // Age holds off history checks until the synchronisers flush.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            p1_aph_reg <= 1'b0;
            p1_due_reg <= 1'b0;
            p1_val_reg <= 8'h00;
            age_reg    <= 3'h0;
        end else begin
            p1_aph_reg <= hsel_i & hready_i & htrans_i[1] & hwrite_i
                          & (haddr_i[7:0] == `GPPA_OFF_P1_LATCH);
            p1_due_reg <= p1_aph_reg;
            if (p1_aph_reg) begin
                p1_val_reg <= hwdata_i[7:0];
            end
            if (age_reg != 3'h7) begin
                age_reg <= age_reg + 3'h1;
            end
        end
    end

    // ======================================================
    // Properties
    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_oe_shape: assert property (age_reg == 3'h7 |->
        port1_pad_oe_o == ~(port1_pad_data_out_o
                            & $past(port1_pad_data_out_o, 2)))
        else $error("port 1 enable shape wrong");
    a_rise_drive: assert property ($rose(port3_pad_data_out_o[1]) |->
        port3_pad_oe_o[1] ##1 port3_pad_oe_o[1])
        else $error("rising output not driven two cycles");
    a_low_sinks: assert property (
        (~port1_pad_data_out_o & ~port1_pad_oe_o) == 8'h00
        && (~port3_pad_data_out_o & ~port3_pad_oe_o) == 8'h00)
        else $error("low output not driven");
    a_reset_inputs: assert property ($rose(arst_n_i) |->
        port1_pad_oe_o == 8'h00 && port3_pad_oe_o == 8'h00
        && port1_pullup_en_o && port3_pullup_en_o)
        else $error("pins not inputs after reset");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready okay");
    a_alt_follow: assert property (age_reg == 3'h7 |->
        port3_alt_in_o == $past(port3_pad_data_in_i, 2))
        else $error("alternate input not the pin");
    a_alt_and: assert property (age_reg == 3'h7 |->
        (port3_pad_data_out_o[7:2] & ~port3_alt_out_i
         & ~$past(port3_alt_out_i)) == 6'h00)
        else $error("low alternate output not passed");
    a_p1_write: assert property (p1_due_reg |->
        ##1 port1_pad_data_out_o == $past(p1_val_reg))
        else $error("port 1 data-out not the latch");
endmodule

bind gppa_port gppa_port_chk #(.BAUD_CYCLES(BAUD_CYCLES)) gppa_port_chk_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .port1_pad_data_out_o(port1_pad_data_out_o),
    .port1_pad_oe_o(port1_pad_oe_o), .port1_pullup_en_o(port1_pullup_en_o),
    .port3_pad_data_in_i(port3_pad_data_in_i),
    .port3_pad_data_out_o(port3_pad_data_out_o),
    .port3_pad_oe_o(port3_pad_oe_o), .port3_pullup_en_o(port3_pullup_en_o),
    .port3_alt_out_i(port3_alt_out_i), .port3_alt_in_o(port3_alt_in_o));
